/* File: core/aer_pkg.sv */
// Package: offsets, field positions and reset values of the error logging registers
`default_nettype none

package aer_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   typedef logic [31:0]  aer_word_t;
   typedef logic [127:0] aer_hdr_t;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [11:0] UNC_STATUS_OFS = 12'hfb8;
   localparam logic [11:0] UNC_MASK_OFS   = 12'hfbc;
   localparam logic [11:0] UNC_SEV_OFS    = 12'hfc0;
   localparam logic [11:0] COR_STATUS_OFS = 12'hfc4;
   localparam logic [11:0] HDR_LOG0_OFS   = 12'hfd0;
   localparam logic [11:0] HDR_LOG1_OFS   = 12'hfd4;
   localparam logic [11:0] HDR_LOG2_OFS   = 12'hfd8;
   localparam logic [11:0] HDR_LOG3_OFS   = 12'hfdc;
   localparam int          HDR_LOG_WORDS  = 4;

   // ****************************************************************
   // Uncorrectable error bit positions
   // ****************************************************************
   localparam int UNC_TRAINING_BIT   = 0;
   localparam int UNC_DL_PROTO_BIT   = 4;
   localparam int UNC_POISONED_BIT   = 12;
   localparam int UNC_FC_PROTO_BIT   = 13;
   localparam int UNC_CPL_TMO_BIT    = 14;
   localparam int UNC_CPL_ABORT_BIT  = 15;
   localparam int UNC_UNEXP_CPL_BIT  = 16;
   localparam int UNC_RX_OVFL_BIT    = 17;
   localparam int UNC_MALFORMED_BIT  = 18;
   localparam int UNC_ECRC_BIT       = 19;
   localparam int UNC_UNSUP_REQ_BIT  = 20;
   localparam int UNC_ACS_VIOL_BIT   = 21;
   localparam int UNC_MC_BLOCKED_BIT = 23;

   // ****************************************************************
   // Correctable error bit positions
   // ****************************************************************
   localparam int COR_RX_ERR_BIT     = 0;
   localparam int COR_BAD_TLP_BIT    = 6;
   localparam int COR_BAD_DLLP_BIT   = 7;
   localparam int COR_REPLAY_ROLL_BIT = 8;
   localparam int COR_REPLAY_TMO_BIT = 12;
   localparam int COR_ADVISORY_BIT   = 13;

   // ****************************************************************
   // Implemented bits and reset values
   // ****************************************************************
   localparam aer_word_t UNC_IMPL      = 32'h00bff011;
   localparam aer_word_t COR_IMPL      = 32'h000031c1;
   localparam aer_word_t UNC_MASK_RST  = 32'h00000000;
   localparam aer_word_t UNC_SEV_RST   = 32'h00062011;
   localparam aer_word_t STATUS_RST    = 32'h00000000;
   localparam aer_word_t HDR_LOG_RST   = 32'h00000000;

endpackage

`default_nettype wire

/* File: core/aer_err_if.sv */
// Interface: reportable uncorrectable events between register bank, header log and message issue
`default_nettype none

interface aer_err_if;
   logic             [31:0]  reportEvt;  // Unmasked uncorrectable events, one-cycle
   logic             [31:0]  severity;   // Current severity bits
   aer_pkg::aer_hdr_t        tlpHdr;     // Header bytes of offending packet
   aer_pkg::aer_word_t       logWord [4];

   modport bank   (output reportEvt, output severity, output tlpHdr, input logWord);
   modport logger (input reportEvt, input tlpHdr, output logWord);
   modport issuer (input reportEvt, input severity);
endinterface

`default_nettype wire

/* File: core/aer_hdr_log.sv */
// Header log: captures the four header words of an unmasked uncorrectable error
`default_nettype none

module aer_hdr_log (
   input  wire logic core_clk,
   input  wire logic rst,
   aer_err_if.logger err
);

   // ****************************************************************
   // Capture
   // ****************************************************************
   genvar w;
   generate
      for (w = 0; w < aer_pkg::HDR_LOG_WORDS; w++) begin : g_word
         // RULE_19: big-endian word capture
         always_ff @(posedge core_clk) begin
            if (rst) begin
               err.logWord[w] <= aer_pkg::HDR_LOG_RST;
            end else if (|err.reportEvt) begin
               // Byte 4w sits in the top lane of word w
               err.logWord[w] <= {err.tlpHdr[32*w +: 8], err.tlpHdr[32*w+8 +: 8],
                                  err.tlpHdr[32*w+16 +: 8], err.tlpHdr[32*w+24 +: 8]};
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

/* File: core/aer_msg_gen.sv */
// Message issue: per reportable error cycle, a fatal pulse, a non-fatal pulse, or both when the severities differ
`default_nettype none

module aer_msg_gen (
   input  wire logic core_clk,
   input  wire logic rst,
   aer_err_if.issuer err,
   output      logic msgFatal,
   output      logic msgNonFatal
);

   // ****************************************************************
   // Severity split
   // ****************************************************************
   // RULE_20: severity picks message
   always_ff @(posedge core_clk) begin
      if (rst) begin
         msgFatal    <= 1'b0;
         msgNonFatal <= 1'b0;
      end else begin
         msgFatal    <= |(err.reportEvt & err.severity);
         msgNonFatal <= |(err.reportEvt & ~err.severity);
      end
   end

endmodule

`default_nettype wire

/* File: core/aer_regs.sv */
// Register bank: uncorrectable mask, severity, status and correctable status
`default_nettype none

// How it works
// RULE_01: Mask bit 0 blocks training error reporting
// RULE_02: Mask bit 4 blocks link protocol errors
// RULE_03: Mask bit 12 blocks poisoned packet reports
// RULE_04: Mask bit 13 blocks flow control errors
// RULE_05: Mask bit 14 blocks completion timeout reports
// RULE_06: Mask bit 15 blocks completer abort reports
// RULE_07: Mask bit 16 blocks unexpected completion reports
// RULE_08: Bits 17-19 block overflow, malformed, ECRC
// RULE_09: Bits 20,21,23 block unsupported, ACS, multicast
// RULE_10: Severity bit one fatal, zero non-fatal
// RULE_11: Correctable status sticky, cleared writing one
// RULE_12: Receiver error sets correctable bit 0
// RULE_13: Bad packet sets correctable bit 6
// RULE_14: Bad link packet sets bit 7
// RULE_15: Replay count rollover sets bit 8
// RULE_16: Replay timer expiry sets bit 12
// RULE_17: Advisory non-fatal error sets bit 13
// RULE_18: Uncorrectable status sets, write one clears
// RULE_19: Unmasked error logs header big-endian
// RULE_20: Unmasked error sends severity-chosen message
// RULE_21: Masks, status reset zero; reserved reads zero
module aer_regs (
   input  wire logic               core_clk,
   input  wire logic               rst,
   input  wire logic               cfgWrEn,
   input  wire logic               cfgRdEn,
   input  wire logic [11:0]        cfgAddr,
   input  wire logic [31:0]        cfgWrData,
   input  wire logic [3:0]         cfgByteEn,
   output      logic [31:0]        cfgRdData,
   output      logic               cfgRdValid,
   input  wire logic [31:0]        uncEvt,
   input  wire logic [31:0]        corrEvt,
   input  wire aer_pkg::aer_hdr_t  tlpHdr,
   output      logic               msgFatal,
   output      logic               msgNonFatal
);

   // ****************************************************************
   // Declarations
   // ****************************************************************
   aer_pkg::aer_word_t uncMask_r;
   aer_pkg::aer_word_t uncSev_r;
   aer_pkg::aer_word_t uncStatus_r;
   aer_pkg::aer_word_t corStatus_r;
   aer_pkg::aer_word_t wrBits;      // Write data gated by byte lanes
   aer_pkg::aer_word_t laneMask;
   aer_pkg::aer_word_t uncSet;
   aer_pkg::aer_word_t corSet;
   aer_pkg::aer_word_t rdMux;
   logic               wrMask;
   logic               wrSev;
   logic               wrUncStatus;
   logic               wrCorStatus;

   aer_err_if err ();

   // ****************************************************************
   // Address decode and byte lanes
   // ****************************************************************
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_lane
         assign laneMask[8*b +: 8] = {8{cfgByteEn[b]}};
      end
   endgenerate

   assign wrBits      = cfgWrData & laneMask;
   assign wrMask      = cfgWrEn && (cfgAddr == aer_pkg::UNC_MASK_OFS);
   assign wrSev       = cfgWrEn && (cfgAddr == aer_pkg::UNC_SEV_OFS);
   assign wrUncStatus = cfgWrEn && (cfgAddr == aer_pkg::UNC_STATUS_OFS);
   assign wrCorStatus = cfgWrEn && (cfgAddr == aer_pkg::COR_STATUS_OFS);

   // ****************************************************************
   // Uncorrectable mask
   // ****************************************************************
   // RULE_21: mask resets clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         uncMask_r <= aer_pkg::UNC_MASK_RST;
      end else if (wrMask) begin
         // Reserved bits never store
         uncMask_r <= ((uncMask_r & ~laneMask) | wrBits) & aer_pkg::UNC_IMPL;
      end
   end

   // ****************************************************************
   // Uncorrectable severity
   // ****************************************************************
   // RULE_10: severity reset classes
   always_ff @(posedge core_clk) begin
      if (rst) begin
         uncSev_r <= aer_pkg::UNC_SEV_RST;
      end else if (wrSev) begin
         uncSev_r <= ((uncSev_r & ~laneMask) | wrBits) & aer_pkg::UNC_IMPL;
      end
   end

   // ****************************************************************
   // Uncorrectable status
   // ****************************************************************
   assign uncSet = uncEvt & aer_pkg::UNC_IMPL;

   // RULE_18: sticky with write-one clear
   always_ff @(posedge core_clk) begin
      if (rst) begin
         uncStatus_r <= aer_pkg::STATUS_RST;
      end else begin
         // New event beats a clear in the same cycle
         uncStatus_r <= (uncStatus_r & ~(wrUncStatus ? wrBits : '0)) | uncSet;
      end
   end

   // ****************************************************************
   // Correctable status
   // ****************************************************************
   // RULE_12: receiver error bit
   assign corSet[aer_pkg::COR_RX_ERR_BIT]      = corrEvt[aer_pkg::COR_RX_ERR_BIT];
   // RULE_13: bad packet bit
   assign corSet[aer_pkg::COR_BAD_TLP_BIT]     = corrEvt[aer_pkg::COR_BAD_TLP_BIT];
   // RULE_14: bad link packet bit
   assign corSet[aer_pkg::COR_BAD_DLLP_BIT]    = corrEvt[aer_pkg::COR_BAD_DLLP_BIT];
   // RULE_15: replay rollover bit
   assign corSet[aer_pkg::COR_REPLAY_ROLL_BIT] = corrEvt[aer_pkg::COR_REPLAY_ROLL_BIT];
   // RULE_16: replay timeout bit
   assign corSet[aer_pkg::COR_REPLAY_TMO_BIT]  = corrEvt[aer_pkg::COR_REPLAY_TMO_BIT];
   // RULE_17: advisory non-fatal bit
   assign corSet[aer_pkg::COR_ADVISORY_BIT]    = corrEvt[aer_pkg::COR_ADVISORY_BIT];
   // Unimplemented positions never set
   assign corSet[5:1]   = '0;
   assign corSet[11:9]  = '0;
   assign corSet[31:14] = '0;

   // RULE_11: sticky, write one clears
   always_ff @(posedge core_clk) begin
      if (rst) begin
         corStatus_r <= aer_pkg::STATUS_RST;
      end else begin
         // Set wins over clear; writing zero keeps the bit
         corStatus_r <= (corStatus_r & ~(wrCorStatus ? wrBits : '0)) | corSet;
      end
   end

   // ****************************************************************
   // Masking toward header log and messages
   // ****************************************************************
   // RULE_01: training mask
   assign err.reportEvt[aer_pkg::UNC_TRAINING_BIT] =
      uncSet[aer_pkg::UNC_TRAINING_BIT] & ~uncMask_r[aer_pkg::UNC_TRAINING_BIT];
   // RULE_02: link protocol mask
   assign err.reportEvt[aer_pkg::UNC_DL_PROTO_BIT] =
      uncSet[aer_pkg::UNC_DL_PROTO_BIT] & ~uncMask_r[aer_pkg::UNC_DL_PROTO_BIT];
   // RULE_03: poisoned packet mask
   assign err.reportEvt[aer_pkg::UNC_POISONED_BIT] =
      uncSet[aer_pkg::UNC_POISONED_BIT] & ~uncMask_r[aer_pkg::UNC_POISONED_BIT];
   // RULE_04: flow control mask
   assign err.reportEvt[aer_pkg::UNC_FC_PROTO_BIT] =
      uncSet[aer_pkg::UNC_FC_PROTO_BIT] & ~uncMask_r[aer_pkg::UNC_FC_PROTO_BIT];
   // RULE_05: completion timeout mask
   assign err.reportEvt[aer_pkg::UNC_CPL_TMO_BIT] =
      uncSet[aer_pkg::UNC_CPL_TMO_BIT] & ~uncMask_r[aer_pkg::UNC_CPL_TMO_BIT];
   // RULE_06: completer abort mask
   assign err.reportEvt[aer_pkg::UNC_CPL_ABORT_BIT] =
      uncSet[aer_pkg::UNC_CPL_ABORT_BIT] & ~uncMask_r[aer_pkg::UNC_CPL_ABORT_BIT];
   // RULE_07: unexpected completion mask
   assign err.reportEvt[aer_pkg::UNC_UNEXP_CPL_BIT] =
      uncSet[aer_pkg::UNC_UNEXP_CPL_BIT] & ~uncMask_r[aer_pkg::UNC_UNEXP_CPL_BIT];
   // RULE_08: overflow, malformed, ECRC masks
   assign err.reportEvt[aer_pkg::UNC_RX_OVFL_BIT] =
      uncSet[aer_pkg::UNC_RX_OVFL_BIT] & ~uncMask_r[aer_pkg::UNC_RX_OVFL_BIT];
   assign err.reportEvt[aer_pkg::UNC_MALFORMED_BIT] =
      uncSet[aer_pkg::UNC_MALFORMED_BIT] & ~uncMask_r[aer_pkg::UNC_MALFORMED_BIT];
   assign err.reportEvt[aer_pkg::UNC_ECRC_BIT] =
      uncSet[aer_pkg::UNC_ECRC_BIT] & ~uncMask_r[aer_pkg::UNC_ECRC_BIT];
   // RULE_09: unsupported, ACS, multicast masks
   assign err.reportEvt[aer_pkg::UNC_UNSUP_REQ_BIT] =
      uncSet[aer_pkg::UNC_UNSUP_REQ_BIT] & ~uncMask_r[aer_pkg::UNC_UNSUP_REQ_BIT];
   assign err.reportEvt[aer_pkg::UNC_ACS_VIOL_BIT] =
      uncSet[aer_pkg::UNC_ACS_VIOL_BIT] & ~uncMask_r[aer_pkg::UNC_ACS_VIOL_BIT];
   assign err.reportEvt[aer_pkg::UNC_MC_BLOCKED_BIT] =
      uncSet[aer_pkg::UNC_MC_BLOCKED_BIT] & ~uncMask_r[aer_pkg::UNC_MC_BLOCKED_BIT];
   // Reserved positions never report
   assign err.reportEvt[3:1]   = '0;
   assign err.reportEvt[11:5]  = '0;
   assign err.reportEvt[22]    = 1'b0;
   assign err.reportEvt[31:24] = '0;

   assign err.severity = uncSev_r;
   assign err.tlpHdr   = tlpHdr;

   // ****************************************************************
   // Header log and error messages
   // ****************************************************************
   // RULE_19: capture on reportable error
   aer_hdr_log u_hdr_log (
      .core_clk (core_clk),
      .rst      (rst),
      .err      (err.logger)
   );

   // RULE_20: message toward root complex
   aer_msg_gen u_msg_gen (
      .core_clk    (core_clk),
      .rst         (rst),
      .err         (err.issuer),
      .msgFatal    (msgFatal),
      .msgNonFatal (msgNonFatal)
   );

   // ****************************************************************
   // Read path
   // ****************************************************************
   // RULE_21: unmapped and reserved read zero
   always_comb begin
      case (cfgAddr)
         aer_pkg::UNC_STATUS_OFS: rdMux = uncStatus_r;
         aer_pkg::UNC_MASK_OFS:   rdMux = uncMask_r;
         aer_pkg::UNC_SEV_OFS:    rdMux = uncSev_r;
         aer_pkg::COR_STATUS_OFS: rdMux = corStatus_r & aer_pkg::COR_IMPL;
         aer_pkg::HDR_LOG0_OFS:   rdMux = err.logWord[0];
         aer_pkg::HDR_LOG1_OFS:   rdMux = err.logWord[1];
         aer_pkg::HDR_LOG2_OFS:   rdMux = err.logWord[2];
         aer_pkg::HDR_LOG3_OFS:   rdMux = err.logWord[3];
         default:                 rdMux = '0;
      endcase
   end

   // Read data one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (rst) begin
         cfgRdData  <= '0;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdValid <= cfgRdEn;
         if (cfgRdEn) begin
            cfgRdData <= rdMux;
         end
      end
   end

endmodule

`default_nettype wire

/* File: testbench/aer_rc_model.sv */
// Root complex model: tallies error messages arriving from the port
`default_nettype none

module aer_rc_model (
   input  wire logic core_clk,
   input  wire logic rst,
   input  wire logic msgFatal,
   input  wire logic msgNonFatal,
   output var  int   fatalCnt,
   output var  int   nonFatalCnt
);
   always_ff @(posedge core_clk) begin
      if (rst) begin
         fatalCnt <= 0;
         nonFatalCnt <= 0;
      end else begin
         fatalCnt <= fatalCnt + int'(msgFatal);
         nonFatalCnt <= nonFatalCnt + int'(msgNonFatal);
      end
   end
endmodule

`default_nettype wire

/* File: testbench/aer_regs_props.sv */
// Checker: port-level properties of the error register bank
`default_nettype none

module aer_regs_props (
   input wire logic              core_clk,
   input wire logic              rst,
   input wire logic              cfgWrEn,
   input wire logic              cfgRdEn,
   input wire logic [11:0]       cfgAddr,
   input wire logic [31:0]       cfgWrData,
   input wire logic [3:0]        cfgByteEn,
   input wire logic [31:0]       cfgRdData,
   input wire logic              cfgRdValid,
   input wire logic [31:0]       uncEvt,
   input wire logic [31:0]       corrEvt,
   input wire aer_pkg::aer_hdr_t tlpHdr,
   input wire logic              msgFatal,
   input wire logic              msgNonFatal
);
   aer_pkg::aer_word_t mask_r;
   aer_pkg::aer_word_t sev_r;
   logic [31:0]        live;

   // Byte-lane merge, reserved bits dropped
   function automatic aer_pkg::aer_word_t merge(aer_pkg::aer_word_t o, logic [31:0] d, logic [3:0] be);
      for (int b = 0; b < 4; b++)
         if (be[b])
            o[8*b+:8] = d[8*b+:8];
      return o & aer_pkg::UNC_IMPL;
   endfunction

   // Shadow of the mask register
   always_ff @(posedge core_clk) begin
      if (rst)
         mask_r <= aer_pkg::UNC_MASK_RST;
      else if (cfgWrEn && cfgAddr == aer_pkg::UNC_MASK_OFS)
         mask_r <= merge(mask_r, cfgWrData, cfgByteEn);
   end

   // Shadow of the severity register
   always_ff @(posedge core_clk) begin
      if (rst)
         sev_r <= aer_pkg::UNC_SEV_RST;
      else if (cfgWrEn && cfgAddr == aer_pkg::UNC_SEV_OFS)
         sev_r <= merge(sev_r, cfgWrData, cfgByteEn);
   end

   // Unmasked reportable events
   assign live = uncEvt & ~mask_r & aer_pkg::UNC_IMPL;

   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);

   // ****************************************************************
   // Properties
   // ****************************************************************
   a_rd_answer: assert property (cfgRdEn |=> cfgRdValid)
      else $error("read not answered");
   a_rd_quiet: assert property (!cfgRdEn |=> !cfgRdValid)
      else $error("stray read valid");
   a_fatal_msg: assert property (|(live & sev_r) |=> msgFatal)
      else $error("fatal message missing");
   a_nonfatal_msg: assert property (|(live & ~sev_r) |=> msgNonFatal)
      else $error("non-fatal message missing");
   a_masked_silent: assert property (!(|live) |=> !msgFatal && !msgNonFatal)
      else $error("message without unmasked event");
   a_sev_readback: assert property (cfgRdEn && cfgAddr == aer_pkg::UNC_SEV_OFS |=> cfgRdData == $past(sev_r))
      else $error("severity readback wrong");
   a_mask_readback: assert property (cfgRdEn && cfgAddr == aer_pkg::UNC_MASK_OFS |=> cfgRdData == $past(mask_r))
      else $error("mask readback wrong");
   a_unmapped_zero: assert property (cfgRdEn && !(cfgAddr inside {[12'hfb8:12'hfc4], [12'hfd0:12'hfdc]})
      |=> cfgRdData == 32'h0) else $error("unmapped read not zero");
   a_corr_sticky: assert property ((|(corrEvt & aer_pkg::COR_IMPL)) ##1 (cfgRdEn && cfgAddr == 12'hfc4)
      |=> (cfgRdData & $past(corrEvt, 2) & aer_pkg::COR_IMPL) == ($past(corrEvt, 2) & aer_pkg::COR_IMPL))
      else $error("correctable status not set");

   c_both_msgs: cover property (msgFatal && msgNonFatal);
   c_masked_evt: cover property (|(uncEvt & mask_r));
   c_corr_read: cover property ((|corrEvt) ##1 cfgRdEn);
endmodule

bind aer_regs aer_regs_props i_props (.core_clk(core_clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
   .cfgAddr(cfgAddr), .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn), .cfgRdData(cfgRdData),
   .cfgRdValid(cfgRdValid), .uncEvt(uncEvt), .corrEvt(corrEvt), .tlpHdr(tlpHdr),
   .msgFatal(msgFatal), .msgNonFatal(msgNonFatal));

`default_nettype wire

/* File: testbench/aer_regs_tb.sv */
// Testbench: reset values, masking, severity, status and header log of the register bank
`default_nettype none

module aer_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic              core_clk, rst, cfgWrEn, cfgRdEn, cfgRdValid, msgFatal, msgNonFatal, fat, nf;
   logic [11:0]       cfgAddr;
   logic [3:0]        cfgByteEn;
   logic [31:0]       cfgWrData, cfgRdData, uncEvt, corrEvt;
   aer_pkg::aer_hdr_t tlpHdr, hLog;
   int                fails, checkCount, cycles, fatalCnt, nonFatalCnt, expF, expN;

   aer_regs i_dut (.core_clk(core_clk), .rst(rst), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn), .cfgAddr(cfgAddr),
      .cfgWrData(cfgWrData), .cfgByteEn(cfgByteEn), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
      .uncEvt(uncEvt), .corrEvt(corrEvt), .tlpHdr(tlpHdr), .msgFatal(msgFatal), .msgNonFatal(msgNonFatal));
   aer_rc_model i_rc (.core_clk(core_clk), .rst(rst), .msgFatal(msgFatal), .msgNonFatal(msgNonFatal),
      .fatalCnt(fatalCnt), .nonFatalCnt(nonFatalCnt));

   // Clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   // ****************************************************************
   // Bus and event tasks
   // ****************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checkCount++;
      if (got !== exp) begin
         fails++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] be);
      @(negedge core_clk);
      cfgWrEn = 1'b1;
      cfgAddr = a;
      cfgWrData = d;
      cfgByteEn = be;
      @(negedge core_clk);
      cfgWrEn = 1'b0;
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      @(negedge core_clk);
      cfgRdEn = 1'b1;
      cfgAddr = a;
      @(negedge core_clk);
      cfgRdEn = 1'b0;
      chk({31'h0, cfgRdValid}, 32'h1);
      chk(cfgRdData, exp);
   endtask

   task automatic evt(input logic [31:0] u, input aer_pkg::aer_hdr_t h);
      @(negedge core_clk);
      uncEvt = u;
      tlpHdr = h;
      @(negedge core_clk);
      uncEvt = 32'h0;
      fat = msgFatal;
      nf = msgNonFatal;
   endtask

   // Header log words, big-endian per word
   task automatic chk_log(input aer_pkg::aer_hdr_t h);
      for (int w = 0; w < aer_pkg::HDR_LOG_WORDS; w++)
         rd(aer_pkg::HDR_LOG0_OFS + 12'(4 * w), {h[32*w+:8], h[32*w+8+:8], h[32*w+16+:8], h[32*w+24+:8]});
   endtask

   // ****************************************************************
   // Scenarios
   // ****************************************************************
   task automatic t_reset();
      rd(aer_pkg::UNC_MASK_OFS, aer_pkg::UNC_MASK_RST);
      rd(aer_pkg::UNC_SEV_OFS, aer_pkg::UNC_SEV_RST);
      rd(aer_pkg::COR_STATUS_OFS, 32'h0);
      rd(aer_pkg::UNC_STATUS_OFS, 32'h0);
      wr(12'hfcc, 32'hffffffff, 4'hf);
      wr(aer_pkg::HDR_LOG0_OFS, 32'hffffffff, 4'hf);
      rd(12'hfcc, 32'h0);
      chk_log('0);
      wr(aer_pkg::UNC_MASK_OFS, 32'hffffffff, 4'hf);
      rd(aer_pkg::UNC_MASK_OFS, aer_pkg::UNC_IMPL);
      $display("test reset done");
   endtask

   task automatic t_mask();
      aer_pkg::aer_hdr_t h;
      for (int b = 0; b < 32; b++) begin
         if (aer_pkg::UNC_IMPL[b]) begin
            for (int n = 0; n < 16; n++)
               h[8*n+:8] = 8'(16 * b + n);
            wr(aer_pkg::UNC_MASK_OFS, 32'h1 << b, 4'hf);
            evt(32'h1 << b, h);
            chk({30'h0, fat, nf}, 32'h0);
            chk_log(hLog);
            wr(aer_pkg::UNC_MASK_OFS, 32'h0, 4'hf);
            evt(32'h1 << b, h);
            chk({30'h0, fat, nf}, {30'h0, aer_pkg::UNC_SEV_RST[b], !aer_pkg::UNC_SEV_RST[b]});
            expF += int'(aer_pkg::UNC_SEV_RST[b]);
            expN += int'(!aer_pkg::UNC_SEV_RST[b]);
            hLog = h;
            chk_log(hLog);
            rd(aer_pkg::UNC_STATUS_OFS, 32'h1 << b);
            wr(aer_pkg::UNC_STATUS_OFS, 32'h1 << b, 4'hf);
            rd(aer_pkg::UNC_STATUS_OFS, 32'h0);
         end
      end
      $display("test mask done");
   endtask

   task automatic t_sev();
      wr(aer_pkg::UNC_SEV_OFS, 32'hffffffff, 4'hf);
      rd(aer_pkg::UNC_SEV_OFS, aer_pkg::UNC_IMPL);
      evt(32'h1 << aer_pkg::UNC_CPL_TMO_BIT, '0);
      chk({30'h0, fat, nf}, 32'h2);
      wr(aer_pkg::UNC_SEV_OFS, 32'h1, 4'h1);
      wr(aer_pkg::UNC_SEV_OFS, 32'h0, 4'he);
      rd(aer_pkg::UNC_SEV_OFS, 32'h1);
      evt(32'h1 | (32'h1 << aer_pkg::UNC_POISONED_BIT), '0);
      chk({30'h0, fat, nf}, 32'h3);
      expF += 2;
      expN += 1;
      $display("test severity done");
   endtask

   task automatic t_corr();
      @(negedge core_clk);
      corrEvt = 32'hffffffff;
      @(negedge core_clk);
      corrEvt = 32'h0;
      cfgRdEn = 1'b1;
      cfgAddr = aer_pkg::COR_STATUS_OFS;
      fat = msgFatal;
      @(negedge core_clk);
      cfgRdEn = 1'b0;
      chk(cfgRdData, aer_pkg::COR_IMPL);
      chk({31'h0, fat}, 32'h0);
      wr(aer_pkg::COR_STATUS_OFS, 32'h00001041, 4'h1);
      wr(aer_pkg::COR_STATUS_OFS, 32'h0, 4'hf);
      rd(aer_pkg::COR_STATUS_OFS, aer_pkg::COR_IMPL & ~32'h41);
      wr(aer_pkg::COR_STATUS_OFS, 32'hffffffff, 4'hf);
      rd(aer_pkg::COR_STATUS_OFS, 32'h0);
      $display("test correctable done");
   endtask

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", checkCount, fails);
      if (fails == 0 && checkCount > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         fails++;
         complete_run();
      end
   end

   // Main sequence
   initial begin
      {rst, cfgWrEn, cfgRdEn, cfgAddr, cfgWrData, cfgByteEn, uncEvt, corrEvt, tlpHdr, hLog} = '0;
      {fails, checkCount, cycles, expF, expN} = '0;
      rst = 1'b1;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_mask();
      t_sev();
      t_corr();
      chk(32'(fatalCnt), 32'(expF));
      chk(32'(nonFatalCnt), 32'(expN));
      complete_run();
   end
endmodule

`default_nettype wire
